// ==== rtl/wakeup_flags_reset_nmi_entry.sv ====
// Wakeup request flags, reset entry sequence and nonmaskable interrupt front end with a Wishbone slave.
//
// Notes on behaviour
// - Flag register bits 7 and 6 read one.
// - Selected edge on interrupt pin sets flag.
// - Flags reset to zero, cleared by writing zero.
// - Reset pin low halts everything at once.
// - Reset initialises CPU state and all registers; the pin reset here leaves the bus slave and low-time registers uncleared.
// - Long enough reset release starts entry sequence.
// - Entry first sets the interrupt mask bit.
// - Vector from 0000-0001 loads program counter.
// - Nonmaskable edge polarity chosen by control bit.
// - Nonmaskable interrupt top priority, ignores mask bit.
// - Each wakeup pin has own polarity select.
// - One common enable gates all wakeup requests.
// - Maskable requests accepted only when mask zero.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`include "wake_map.svh"
`timescale 1ns/1ps
`default_nettype none

module wakeup_flags_reset_nmi_entry
    import wake_pkg::*;
#(
    parameter int NWAKE = 6
) (
    input  wire logic             clk_i,              // System clock, 125 MHz.
    input  wire logic             rst_i,              // Synchronous reset, active high.
    input  wire logic             chip_reset_pin_n_i, // Chip reset pin, active low.
    input  wire logic [NWAKE-1:0] wake_pin_i,         // Wakeup pins 5 down to 0.
    input  wire logic             nmi_pin_i,          // Nonmaskable interrupt pin.
    input  wire logic             wb_cyc_i,           // Wishbone cycle.
    input  wire logic             wb_stb_i,           // Wishbone strobe.
    input  wire logic             wb_we_i,            // Wishbone write enable.
    input  wire logic [7:0]       wb_adr_i,           // Wishbone byte address.
    input  wire logic [3:0]       wb_sel_i,           // Wishbone byte selects.
    input  wire logic [31:0]      wb_dat_i,           // Wishbone write data.
    output logic      [31:0]      wb_dat_o,           // Wishbone read data.
    output logic                  wb_ack_o,           // Wishbone acknowledge.
    output logic                  vec_req_o,          // Vector byte read request.
    output logic      [15:0]      vec_addr_o,         // Vector byte address.
    input  wire logic             vec_ack_i,          // Vector byte valid.
    input  wire logic [7:0]       vec_data_i,         // Vector byte data.
    output logic                  cpu_run_o,          // CPU may execute.
    output logic      [15:0]      pc_o,               // Start address for the CPU.
    output logic                  pc_load_o,          // Pulse: pc_o holds the start address.
    output logic                  imask_o,            // Interrupt mask bit of the condition code register.
    output logic                  nmi_take_o,         // Pulse: nonmaskable interrupt accepted.
    output logic                  wake_take_o,        // Pulse: wakeup interrupt accepted.
    output logic                  irq_o               // Level interrupt, unmasked status pending.
);

    // Pin low resets the control, flag and entry registers; the bus slave and low-time registers clear on the system reset, the low-time ones also on a high pin.
    wire reset_all = rst_i | ~chip_reset_pin_n_i;

    boot_state_t state_r;
    boot_state_t state_nxt;
    logic [3:0]        low_cnt_r;
    logic [NWAKE-1:0]  flags_r;
    logic [NWAKE-1:0]  wake_rise_r;
    logic [NWAKE-1:0]  pin_func_r;
    logic              nmi_rise_r;
    logic              group_en_r;
    logic              imask_r;
    logic              nmi_pend_r;
    logic [2:0]        irq_stat_r;
    logic [2:0]        irq_mask_r;
    logic [15:0]       pc_r;
    logic              pc_load_r;
    logic              ack_r;
    logic [31:0]       rdata_r;

    wire [NWAKE-1:0] wake_edge;
    wire             nmi_edge;

    // A pin whose function select is zero gives no edge, so turning the function on later sets no flag by itself.
    edge_detect #(.N(NWAKE)) u_wake_edge (
        .clk_i  (clk_i),
        .rst_i  (reset_all),
        .pin_i  (wake_pin_i),
        .rise_i (wake_rise_r),
        .use_i  (pin_func_r),
        .edge_o (wake_edge)
    );

    edge_detect #(.N(1)) u_nmi_edge (
        .clk_i  (clk_i),
        .rst_i  (reset_all),
        .pin_i  (nmi_pin_i),
        .rise_i (nmi_rise_r),
        .use_i  (1'b1),
        .edge_o (nmi_edge)
    );

    // Bus decode. Writes take effect on the edge at which the master sees ack.
    wire       bus_req  = wb_cyc_i & wb_stb_i;
    wire       wr_ok    = bus_req & wb_we_i & ack_r & wb_sel_i[0];
    wire [7:0] wd       = wb_dat_i[7:0];
    wire       wr_flags = wr_ok & (wb_adr_i == `WK_OFS_FLAGS);
    wire       wr_edge1 = wr_ok & (wb_adr_i == `WK_OFS_EDGE_ONE);
    wire       wr_edge2 = wr_ok & (wb_adr_i == `WK_OFS_EDGE_TWO);
    wire       wr_ien   = wr_ok & (wb_adr_i == `WK_OFS_IEN_ONE);
    wire       wr_func  = wr_ok & (wb_adr_i == `WK_OFS_PIN_FUNC);
    wire       wr_stat  = wr_ok & (wb_adr_i == `WK_OFS_IRQ_STAT);
    wire       wr_mask  = wr_ok & (wb_adr_i == `WK_OFS_IRQ_MASK);
    wire       wr_ccr   = wr_ok & (wb_adr_i == `WK_OFS_CCR);

    // Only written zeros clear; ones and the reserved bits are ignored.
    // A set in the same cycle as a clear wins so that no edge is lost.
    wire [NWAKE-1:0] flags_nxt;
    genvar fi;
    generate
        for (fi = 0; fi < NWAKE; fi++)
        begin : g_flag
            wire clr_bit = wr_flags & ~wd[fi];
            wire set_bit = wake_edge[fi];
            assign flags_nxt[fi] = (flags_r[fi] & ~clr_bit) | set_bit;
        end
    endgenerate

    // Interrupt acceptance only while the CPU runs, so nothing is taken before the stack is set up.
    wire running   = (state_r == ST_RUN);
    wire wake_pend = group_en_r & (|flags_r);
    wire nmi_take  = running & nmi_pend_r;
    wire wake_take = running & wake_pend & ~imask_r & ~nmi_pend_r;

    wire [2:0] irq_event = {pc_load_r, nmi_edge, |wake_edge};
    wire [2:0] stat_nxt;

    // Status bits stay set until a one is written; an event in the clearing cycle keeps its bit.
    genvar si;
    generate
        for (si = 0; si <= `WK_IRQ_BOOT_BIT; si++)
        begin : g_stat
            wire clr_bit = wr_stat & wd[si];
            assign stat_nxt[si] = (irq_stat_r[si] & ~clr_bit) | irq_event[si];
        end
    endgenerate

    wire [7:0] flags_rd = `WK_FLAGS_RSVD | {{(8-NWAKE){1'b0}}, flags_r};
    // Only the mask bit of the condition code register lives here; the other bits read zero.
    wire [7:0] ccr_rd   = {imask_r, 7'h00};

    logic [31:0] rd_mux;
    always_comb
    begin
        case (wb_adr_i)
            `WK_OFS_FLAGS:    rd_mux = {24'h000000, flags_rd};
            `WK_OFS_EDGE_ONE: rd_mux = {31'h00000000, nmi_rise_r};
            `WK_OFS_EDGE_TWO: rd_mux = {{(32-NWAKE){1'b0}}, wake_rise_r};
            `WK_OFS_IEN_ONE:  rd_mux = {31'h00000000, group_en_r};
            `WK_OFS_PIN_FUNC: rd_mux = {{(32-NWAKE){1'b0}}, pin_func_r};
            `WK_OFS_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_r};
            `WK_OFS_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_r};
            `WK_OFS_CCR:      rd_mux = {24'h000000, ccr_rd};
            `WK_OFS_PC:       rd_mux = {16'h0000, pc_r};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // Reset entry sequencer.
    // The mask bit is set before the fetch so that no maskable request slips in while the vector loads.
    wire long_low = (low_cnt_r >= `WK_RESET_MIN_CYC);
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_HALT:     state_nxt = long_low ? ST_SET_I : ST_WAIT_REL;
            ST_WAIT_REL: state_nxt = ST_WAIT_REL;
            ST_SET_I:    state_nxt = ST_FETCH_HI;
            ST_FETCH_HI: state_nxt = vec_ack_i ? ST_FETCH_LO : ST_FETCH_HI;
            ST_FETCH_LO: state_nxt = vec_ack_i ? ST_RUN : ST_FETCH_LO;
            ST_RUN:      state_nxt = ST_RUN;
            default:     state_nxt = ST_HALT;
        endcase
    end

    // The low-time counter must survive the pin reset, so only the system reset and a high pin clear it.
    // A release after too short a low time leaves the device halted until a proper pulse.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            low_cnt_r <= 4'h0;
        else if (chip_reset_pin_n_i)
            low_cnt_r <= 4'h0;
        else if (!long_low)
            low_cnt_r <= low_cnt_r + 4'h1;
    end

    // The pin release is only evaluated in ST_HALT; the count is sampled into low_seen_r on the last cycle before release.
    logic low_seen_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            low_seen_r <= 1'b0;
        else if (!chip_reset_pin_n_i)
            low_seen_r <= long_low | (low_cnt_r == (`WK_RESET_MIN_CYC - 4'h1));
        else
            low_seen_r <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_all)
            state_r <= ST_HALT;
        else if (state_r == ST_HALT)
            state_r <= low_seen_r ? ST_SET_I : ST_WAIT_REL;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_all)
        begin
            imask_r   <= 1'b0;
            pc_r      <= 16'h0000;
            pc_load_r <= 1'b0;
        end
        else
        begin
            pc_load_r <= (state_r == ST_FETCH_LO) & vec_ack_i;
            if (state_r == ST_SET_I)
                imask_r <= 1'b1;
            else if (wake_take)
                imask_r <= 1'b1;
            else if (wr_ccr)
                imask_r <= wd[`WK_CCR_I_BIT];
            // The start address is assembled high byte first, in the order of the fetch.
            if ((state_r == ST_FETCH_HI) & vec_ack_i)
                pc_r[15:8] <= vec_data_i;
            if ((state_r == ST_FETCH_LO) & vec_ack_i)
                pc_r[7:0] <= vec_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_all)
        begin
            flags_r     <= '0;
            wake_rise_r <= '0;
            pin_func_r  <= '0;
            nmi_rise_r  <= 1'b0;
            group_en_r  <= 1'b0;
            nmi_pend_r  <= 1'b0;
            irq_stat_r  <= 3'h0;
            irq_mask_r  <= 3'h0;
        end
        else
        begin
            flags_r    <= flags_nxt;
            irq_stat_r <= stat_nxt;
            nmi_pend_r <= nmi_edge | (nmi_pend_r & ~nmi_take);
            if (wr_edge1)
                nmi_rise_r <= wd[`WK_NMI_EDGE_BIT];
            if (wr_edge2)
                wake_rise_r <= wd[NWAKE-1:0];
            if (wr_ien)
                group_en_r <= wd[`WK_GROUP_EN_BIT];
            if (wr_func)
                pin_func_r <= wd[NWAKE-1:0];
            if (wr_mask)
                irq_mask_r <= wd[2:0];
        end
    end

    // Bus slave: ack one cycle after the request, dropped the cycle after.
    // Only byte lane zero carries register data; a write without it is acknowledged and dropped.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            ack_r <= bus_req & ~ack_r;
            if (bus_req & ~ack_r)
                rdata_r <= rd_mux;
        end
    end

    assign wb_ack_o    = ack_r;
    assign wb_dat_o    = rdata_r;
    assign vec_req_o   = (state_r == ST_FETCH_HI) | (state_r == ST_FETCH_LO);
    assign vec_addr_o  = (state_r == ST_FETCH_LO) ? `WK_VEC_LO_ADDR : `WK_VEC_HI_ADDR;
    assign cpu_run_o   = running;
    assign pc_o        = pc_r;
    assign pc_load_o   = pc_load_r;
    assign imask_o     = imask_r;
    assign nmi_take_o  = nmi_take;
    assign wake_take_o = wake_take;
    assign irq_o       = |(irq_stat_r & irq_mask_r);

endmodule // wakeup_flags_reset_nmi_entry

`default_nettype wire

// ==== rtl/wake_map.svh ====
// Register offsets, field positions, reset values and timing counts of the wakeup and reset entry block.
`ifndef WAKE_MAP_SVH
`define WAKE_MAP_SVH

`define WK_OFS_FLAGS      8'h00
`define WK_OFS_EDGE_ONE   8'h04
`define WK_OFS_EDGE_TWO   8'h08
`define WK_OFS_IEN_ONE    8'h0C
`define WK_OFS_PIN_FUNC   8'h10
`define WK_OFS_IRQ_STAT   8'h14
`define WK_OFS_IRQ_MASK   8'h18
`define WK_OFS_CCR        8'h1C
`define WK_OFS_PC         8'h20

`define WK_FLAGS_RSVD     8'hC0
`define WK_NMI_EDGE_BIT   0
`define WK_GROUP_EN_BIT   0
`define WK_CCR_I_BIT      7
`define WK_IRQ_WAKE_BIT   0
`define WK_IRQ_NMI_BIT    1
`define WK_IRQ_BOOT_BIT   2

`define WK_VEC_HI_ADDR    16'h0000
`define WK_VEC_LO_ADDR    16'h0001
`define WK_RESET_MIN_CYC  4'hA

`endif

// ==== rtl/wake_pkg.sv ====
// Types shared by the wakeup flag, reset entry and nonmaskable interrupt logic.
package wake_pkg;

    typedef enum logic [2:0]
    {
        ST_HALT     = 3'b000,
        ST_WAIT_REL = 3'b001,
        ST_SET_I    = 3'b010,
        ST_FETCH_HI = 3'b011,
        ST_FETCH_LO = 3'b100,
        ST_RUN      = 3'b101
    } boot_state_t;

endpackage

// ==== rtl/edge_detect.sv ====
// Per-pin edge detector with individual polarity select and pin function gate.
`timescale 1ns/1ps
`default_nettype none

module edge_detect #(
    parameter int N = 6
) (
    input  wire logic         clk_i,   // System clock.
    input  wire logic         rst_i,   // Synchronous reset, active high.
    input  wire logic [N-1:0] pin_i,   // Pin levels, synchronous to clk_i.
    input  wire logic [N-1:0] rise_i,  // One selects rising edge, zero falling.
    input  wire logic [N-1:0] use_i,   // One where the pin is an interrupt input.
    output logic      [N-1:0] edge_o   // One-cycle pulse per detected edge.
);

    logic [N-1:0] prev_r;
    logic         valid_r;

    // The first sample after reset only primes the history so that a pin idling high gives no false edge.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_r  <= '0;
            valid_r <= 1'b0;
        end
        else
        begin
            prev_r  <= pin_i;
            valid_r <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_bit
            wire rise_seen = pin_i[g] & ~prev_r[g];
            wire fall_seen = ~pin_i[g] & prev_r[g];
            assign edge_o[g] = valid_r & use_i[g] & (rise_i[g] ? rise_seen : fall_seen);
        end
    endgenerate

endmodule // edge_detect

`default_nettype wire

// ==== test/wake_entry_monitor.sv ====
// Assertion checker for the wakeup flag and reset entry block.
`include "wake_map.svh"
`timescale 1ns/1ps
`default_nettype none

module wake_entry_monitor (
    input wire logic        clk_i,              // clock
    input wire logic        rst_i,              // reset
    input wire logic        chip_reset_pin_n_i, // pin reset
    input wire logic        wb_we_i,            // write
    input wire logic [7:0]  wb_adr_i,           // address
    input wire logic [31:0] wb_dat_o,           // read data
    input wire logic        wb_ack_o,           // ack
    input wire logic        vec_req_o,          // fetch
    input wire logic [15:0] vec_addr_o,         // fetch address
    input wire logic        vec_ack_i,          // fetch ack
    input wire logic [7:0]  vec_data_i,         // fetch byte
    input wire logic        cpu_run_o,          // running
    input wire logic [15:0] pc_o,               // start address
    input wire logic        pc_load_o,          // load pulse
    input wire logic        imask_o,            // mask bit
    input wire logic        nmi_take_o,         // nmi taken
    input wire logic        wake_take_o         // wake taken
);
    // Low cycles of the reset pin, saturating well above the minimum so short and long pulses differ.
    logic [3:0] low_cnt_r;
    logic [3:0] low_cnt_nxt;
    assign low_cnt_nxt = chip_reset_pin_n_i ? 4'h0 : ((low_cnt_r == 4'hF) ? 4'hF : low_cnt_r + 4'h1);
    always_ff @(posedge clk_i)
    begin
        low_cnt_r <= rst_i ? 4'h0 : low_cnt_nxt;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rsvd; wb_ack_o && !wb_we_i && wb_adr_i == `WK_OFS_FLAGS |-> wb_dat_o[7:6] == 2'h3; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved flag bits not one");
    property p_halt; !chip_reset_pin_n_i |=> !cpu_run_o && !vec_req_o && !imask_o; endproperty
    a_halt: assert property (p_halt) else $error("pin reset did not halt");
    property p_short; $rose(chip_reset_pin_n_i) && low_cnt_r < 4'hA |-> !vec_req_o [*8]; endproperty
    a_short: assert property (p_short) else $error("short reset started entry");
    property p_long; $rose(chip_reset_pin_n_i) && low_cnt_r >= 4'hA |-> ##[1:4] vec_req_o; endproperty
    a_long: assert property (p_long) else $error("entry did not start");
    property p_mask_first; vec_req_o |-> imask_o; endproperty
    a_mask_first: assert property (p_mask_first) else $error("fetch before mask set");
    property p_order; vec_req_o && vec_ack_i && vec_addr_o == 16'h0000 |=> vec_req_o && vec_addr_o == 16'h0001; endproperty
    a_order: assert property (p_order) else $error("vector fetch order wrong");
    property p_load; vec_req_o && vec_ack_i && vec_addr_o == 16'h0001 |=> pc_load_o && cpu_run_o
        && pc_o[7:0] == $past(vec_data_i); endproperty
    a_load: assert property (p_load) else $error("start address not loaded");
    property p_nmi; nmi_take_o |-> cpu_run_o && !wake_take_o; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi lost priority");
    property p_wake; wake_take_o |-> !imask_o ##1 imask_o; endproperty
    a_wake: assert property (p_wake) else $error("wake taken while masked");
    c_boot: cover property (pc_load_o);
    c_nmi: cover property (nmi_take_o);
    c_wake: cover property (wake_take_o);
endmodule // wake_entry_monitor
`default_nettype wire

// ==== test/vec_rom_model.sv ====
// Vector memory answering the reset vector fetch with a chosen wait.
`timescale 1ns/1ps
`default_nettype none

module vec_rom_model #(
    parameter logic [15:0] VEC = 16'h1234
) (
    input  wire logic        clk_i,      // clock
    input  wire logic        rst_i,      // reset
    input  wire logic        vec_req_i,  // fetch request
    input  wire logic [15:0] vec_addr_i, // fetch address
    input  wire logic [2:0]  lat_i,      // wait cycles
    output logic             vec_ack_o,  // byte valid
    output logic      [7:0]  vec_data_o  // byte
);
    logic [2:0] wait_r;
    logic [7:0] junk_r;
    logic       ack_nxt;
    assign ack_nxt = vec_req_i && !vec_ack_o && wait_r >= lat_i;
    // Outside the ack cycle the byte churns, so a latch at the wrong edge is caught.
    assign vec_data_o = !vec_ack_o ? junk_r : ((vec_addr_i == 16'h0000) ? VEC[15:8] : VEC[7:0]);
    always_ff @(posedge clk_i)
    begin
        vec_ack_o <= !rst_i && ack_nxt;
        wait_r    <= (vec_req_i && !ack_nxt) ? wait_r + 3'h1 : 3'h0;
        junk_r    <= rst_i ? 8'hA5 : ~junk_r ^ {5'h0, wait_r};
    end
endmodule // vec_rom_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the wakeup flag, reset entry and nonmaskable interrupt block.
`include "wake_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    localparam logic [15:0] VEC = 16'hB47C;
    logic        clk_i = 1'b0, rst_i = 1'b1, pin_n = 1'b1, nmi = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [5:0]  wpin = 6'h0, pol, func, keep;
    logic [7:0]  adr = 8'h0, vdata;
    logic [31:0] wdat = 32'h0, rd, dat_o;
    logic [15:0] vaddr, pc;
    logic [2:0]  lat = 3'h0;
    logic [3:0]  sel = 4'hF, bsel = 4'hF;
    logic        ack, vreq, vack, run, pcl, imask, ntake, wtake, irq;
    int          n_fail = 0, comparisons = 0, cyc_cnt = 0, n_nmi = 0, n_wake = 0, j;

    always #4 clk_i = ~clk_i;

    wakeup_flags_reset_nmi_entry #(.NWAKE(6)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .chip_reset_pin_n_i(pin_n), .wake_pin_i(wpin), .nmi_pin_i(nmi),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .vec_req_o(vreq), .vec_addr_o(vaddr), .vec_ack_i(vack),
        .vec_data_i(vdata), .cpu_run_o(run), .pc_o(pc), .pc_load_o(pcl), .imask_o(imask),
        .nmi_take_o(ntake), .wake_take_o(wtake), .irq_o(irq));
    vec_rom_model #(.VEC(VEC)) rom (.clk_i(clk_i), .rst_i(rst_i), .vec_req_i(vreq), .vec_addr_i(vaddr),
        .lat_i(lat), .vec_ack_o(vack), .vec_data_o(vdata));

    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (ntake === 1'b1) n_nmi++;
        if (wtake === 1'b1) n_wake++;
        if (rst_i === 1'b0)
            `CHK("take_known", 1'b0, $isunknown({ntake, wtake, irq, run}))
        if (cyc_cnt == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end

    function automatic logic [31:0] flags_rd(input logic [5:0] f, input logic [5:0] k);
        return {24'h0, 2'h3, f & k};
    endfunction

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, bsel, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    task automatic pin_reset(input int n);
        @(posedge clk_i);
        pin_n <= 1'b0;
        repeat (n) @(posedge clk_i);
        pin_n <= 1'b1;
    endtask

    task automatic boot_chk();
        j = 0;
        while (pcl !== 1'b1 && j < 100)
        begin
            @(posedge clk_i);
            j++;
        end
        `CHK("pc", VEC, pc)
        `CHK("imask", 1'b1, imask)
        `CHK("run", 1'b1, run)
    endtask

    initial
    begin
        j = $urandom(32'hDA4B8B1B);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk("flags", `WK_OFS_FLAGS, flags_rd(6'h0, 6'h0));
        lat <= 3'($urandom % 8);
        pin_reset(12);
        boot_chk();
        rchk("pc_reg", `WK_OFS_PC, {16'h0, VEC});
        rchk("unmapped", 8'h40, 32'h0);
        pol = 6'($urandom);
        j = 1 + $urandom % 5;
        func = 6'h3F & ~(6'h1 << j);
        bus(1'b1, `WK_OFS_EDGE_TWO, {26'h0, pol});
        wpin <= ~pol;
        repeat (3) @(posedge clk_i);
        bus(1'b1, `WK_OFS_PIN_FUNC, {26'h0, func});
        wpin <= pol;
        repeat (3) @(posedge clk_i);
        rchk("set", `WK_OFS_FLAGS, flags_rd(func, 6'h3F));
        keep = 6'($urandom) | 6'h01;
        bus(1'b1, `WK_OFS_FLAGS, {26'h0, keep});
        wpin <= ~pol;
        repeat (3) @(posedge clk_i);
        rchk("clear", `WK_OFS_FLAGS, flags_rd(func, keep));
        bsel = 4'hE;
        bus(1'b1, `WK_OFS_FLAGS, 32'h0);
        bsel = 4'hF;
        rchk("sel_off", `WK_OFS_FLAGS, flags_rd(func, keep));
        @(posedge clk_i);
        `CHK("irq_masked", 1'b0, irq)
        bus(1'b1, `WK_OFS_IRQ_MASK, 32'h1);
        @(posedge clk_i);
        `CHK("irq_on", 1'b1, irq)
        bus(1'b1, `WK_OFS_IRQ_STAT, 32'h1);
        @(posedge clk_i);
        `CHK("irq_off", 1'b0, irq)
        bus(1'b1, `WK_OFS_IEN_ONE, 32'h1);
        repeat (4) @(posedge clk_i);
        `CHK("wake_held", 0, n_wake)
        bus(1'b1, `WK_OFS_IEN_ONE, 32'h0);
        bus(1'b1, `WK_OFS_CCR, 32'h0);
        repeat (4) @(posedge clk_i);
        `CHK("wake_gated", 0, n_wake)
        bus(1'b1, `WK_OFS_IEN_ONE, 32'h1);
        repeat (4) @(posedge clk_i);
        `CHK("wake_taken", 1, n_wake)
        `CHK("wake_mask", 1'b1, imask)
        nmi <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK("nmi_wrong_edge", 0, n_nmi)
        nmi <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK("nmi_fall", 1, n_nmi)
        bus(1'b1, `WK_OFS_EDGE_ONE, 32'h1);
        nmi <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK("nmi_rise", 2, n_nmi)
        pin_reset(9);
        repeat (20) @(posedge clk_i);
        `CHK("halted", 1'b0, run)
        rchk("flags_init", `WK_OFS_FLAGS, flags_rd(6'h0, 6'h0));
        lat <= 3'($urandom % 8);
        pin_reset(10);
        boot_chk();
        rchk("ccr", `WK_OFS_CCR, 32'h80);
        stop_test();
    end
endmodule // tb_top

bind wakeup_flags_reset_nmi_entry wake_entry_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .chip_reset_pin_n_i(chip_reset_pin_n_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o), .vec_ack_i(vec_ack_i),
    .vec_data_i(vec_data_i), .cpu_run_o(cpu_run_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
    .imask_o(imask_o), .nmi_take_o(nmi_take_o), .wake_take_o(wake_take_o));
`default_nettype wire
